// ---- inc/irq_pkg.sv ----
// constants for the interrupt handler: source counts, vectors, call timing
// assumes one system clock at 100 MHz and a sequencer that reports instruction ends
// Notes on behaviour
// RQ1 - twenty-two sources, each low or high priority
// RQ2 - source condition sets its pending flag
// RQ3 - enabled pending flag calls vector after instruction
// RQ4 - return resumes the interrupted instruction stream
// RQ5 - flags set regardless; disabled flags ignored
// RQ6 - per-source enables honoured only under global enable
// RQ7 - global enable low blocks every request
// RQ8 - some flags auto-clear on vectoring, others stay
// RQ9 - flag left set re-enters after one instruction
// RQ10 - twelve peripheral slots, ten pin slots
// RQ11 - software set acts like a hardware event
// RQ12 - high preempts low; high never preempted
// RQ13 - high level first, then fixed source order
// RQ14 - sampled every clock; one detect, four call
// RQ15 - equal or lower waits for return plus one
// RQ16 - vector is 0x0003 plus eight per index
package irq_pkg;
  localparam int          NUM_SRC     = 22;
  localparam int          NUM_PERIPH  = 12;
  localparam int          NUM_EXT     = 10;
  localparam int          IDX_W       = 5;
  localparam int          VEC_W       = 16;
  localparam int          EXT_BASE    = NUM_PERIPH;
  localparam logic [15:0] VEC_BASE    = 16'h0003;
  localparam int          VEC_SHIFT   = 3;
  // slots whose flags hardware clears when the call is made
  localparam logic [21:0] AUTO_CLR    = 22'h3ff000;
  localparam logic [21:0] FLAG_RESET  = 22'h000000;
  localparam int          CLK_NS      = 10;
  localparam int          CALL_NS     = 40;
  localparam int          CALL_CYC    = (CALL_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0]  CALL_CNT    = 3'(CALL_CYC);
endpackage

// ---- inc/arb_if.sv ----
// carries eligible request vectors to the arbiter and its decision back
// assumes both ends run on the system clock; the arbiter is combinational
`timescale 1ns/100ps
`default_nettype none
interface arb_if;
  logic [21:0] hi_req;
  logic [21:0] lo_req;
  logic        valid;
  logic        hi_win;
  logic [4:0]  idx;
  modport handler (output hi_req, output lo_req, input valid, input hi_win, input idx);
  modport arbiter (input hi_req, input lo_req, output valid, output hi_win, output idx);
endinterface
`default_nettype wire

// ---- design/irq_arbiter.sv ----
// fixed-order two-level arbiter for the interrupt handler
// assumes request vectors are already gated by enables and service state
`timescale 1ns/100ps
`default_nettype none
module irq_arbiter (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  arb_if.arbiter   arb
);
  logic [21:0] pick;
  logic [4:0]  idx_next;

  // high level wins; lowest index wins inside a level
  assign pick       = (|arb.hi_req) ? arb.hi_req : arb.lo_req; // RQ13
  assign arb.valid  = |pick;
  assign arb.hi_win = |arb.hi_req;

  always_comb begin
    idx_next = '0;
    for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pick[i]) begin
        idx_next = 5'(i); // RQ13
      end
    end
  end
  assign arb.idx = idx_next;

  hi_first_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RQ13
    (|arb.hi_req) |-> (arb.hi_win && arb.hi_req[arb.idx]))
    else $error("high level request lost to low level");
endmodule
`default_nettype wire

// ---- design/cpu_interrupt_handler.sv ----
// interrupt handler: pending flags, enables, priority, call and return control
// assumes sequencer pulses instr_done_i at each instruction end, with return_from_irq_op_done_i
// in the same cycle for a return; peripheral events come from the system clock
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_handler #(
  parameter logic [21:0] AUTO_CLR_MASK = irq_pkg::AUTO_CLR
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [11:0] periph_event_i,
  input  wire logic [9:0]  ext_pin_n_i,
  input  wire logic [9:0]  ext_pin_used_i,
  input  wire logic [21:0] sw_flag_set_i,
  input  wire logic [21:0] sw_flag_clr_i,
  input  wire logic        global_irq_enable_i,
  input  wire logic [21:0] src_enable_i,
  input  wire logic [21:0] src_high_prio_i,
  input  wire logic        instr_done_i,
  input  wire logic        return_from_irq_op_done_i,
  output logic [21:0]      pending_o,
  output logic             call_start_o,
  output logic [15:0]      call_vector_o,
  output logic             call_busy_o,
  output logic             in_service_hi_o,
  output logic             in_service_lo_o
);
  arb_if arb ();

  logic [9:0]  pin_meta_reg;
  logic [9:0]  pin_sync_reg;
  logic [9:0]  pin_prev_reg;
  logic [9:0]  pin_fall;
  logic [21:0] hw_set;
  logic [21:0] flag_reg;
  logic [21:0] enabled;
  logic        req_reg;
  logic        req_hi_reg;
  logic [4:0]  req_idx_reg;
  logic        take;
  logic [21:0] take_onehot;
  logic        svc_hi_reg;
  logic        svc_lo_reg;
  logic [2:0]  call_cnt_reg;
  logic [15:0] vector_reg;
  logic        start_reg;

  irq_arbiter u_arb (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .arb       (arb.arbiter)
  );

  // pins are asynchronous; only the second and third stages are read by logic
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= '1;
      pin_sync_reg <= '1;
      pin_prev_reg <= '1;
    end else begin
      pin_meta_reg <= ext_pin_n_i;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // active-low edge inputs; unused pins never set their slot
  assign pin_fall = pin_prev_reg & ~pin_sync_reg & ext_pin_used_i;   // RQ10
  assign hw_set   = {pin_fall, periph_event_i};                      // RQ10

  assign take_onehot = take ? (22'h000001 << req_idx_reg) : 22'h000000;

  // one flag per source; a set in the same cycle as a clear wins
  generate
    for (genvar k = 0; k < irq_pkg::NUM_SRC; k++) begin : g_flag // RQ1
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          flag_reg[k] <= irq_pkg::FLAG_RESET[k];
        end else if (hw_set[k] || sw_flag_set_i[k]) begin
          flag_reg[k] <= 1'b1; // RQ2 RQ5 RQ11
        end else if (sw_flag_clr_i[k] || (take_onehot[k] && AUTO_CLR_MASK[k])) begin
          flag_reg[k] <= 1'b0; // RQ8
        end
      end

      flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RQ2
        (hw_set[k] || sw_flag_set_i[k]) |=> flag_reg[k])
        else $error("pending flag not set by its event");
    end
  endgenerate
  assign pending_o = flag_reg;

  // flags reach the arbiter only under both enables and service state
  assign enabled     = global_irq_enable_i ? (flag_reg & src_enable_i) : 22'h000000; // RQ6 RQ7
  assign arb.hi_req  = svc_hi_reg ? 22'h000000 : (enabled & src_high_prio_i);       // RQ12
  assign arb.lo_req  = (svc_hi_reg || svc_lo_reg) ? 22'h000000
                                                  : (enabled & ~src_high_prio_i);   // RQ15

  // requests are sampled and decoded every clock
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      req_reg     <= 1'b0;
      req_hi_reg  <= 1'b0;
      req_idx_reg <= '0;
    end else begin
      req_reg     <= arb.valid; // RQ14
      req_hi_reg  <= arb.hi_win;
      req_idx_reg <= arb.idx;
    end
  end

  // the return cycle itself never takes; the next instruction end may
  assign take = req_reg && instr_done_i && !return_from_irq_op_done_i && (call_cnt_reg == 3'h0); // RQ3 RQ9

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      call_cnt_reg <= 3'h0;
    end else if (take) begin
      call_cnt_reg <= irq_pkg::CALL_CNT; // RQ14
    end else if (call_cnt_reg != 3'h0) begin
      call_cnt_reg <= call_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      start_reg  <= 1'b0;
      vector_reg <= irq_pkg::VEC_BASE;
    end else begin
      start_reg <= take; // RQ3
      if (take) begin
        vector_reg <= irq_pkg::VEC_BASE + (16'(req_idx_reg) << irq_pkg::VEC_SHIFT); // RQ16
      end
    end
  end

  // service state: a return closes the innermost level
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      svc_hi_reg <= 1'b0;
      svc_lo_reg <= 1'b0;
    end else if (take) begin
      if (req_hi_reg) begin
        svc_hi_reg <= 1'b1; // RQ12
      end else begin
        svc_lo_reg <= 1'b1;
      end
    end else if (return_from_irq_op_done_i) begin
      if (svc_hi_reg) begin
        svc_hi_reg <= 1'b0; // RQ4
      end else begin
        svc_lo_reg <= 1'b0; // RQ4
      end
    end
  end

  assign call_start_o    = start_reg;
  assign call_vector_o   = vector_reg;
  assign call_busy_o     = call_cnt_reg != 3'h0;
  assign in_service_hi_o = svc_hi_reg;
  assign in_service_lo_o = svc_lo_reg;

  sequence call_window_s;
    call_busy_o [*4] ##1 !call_busy_o;
  endsequence

  call_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RQ14
    call_start_o |-> call_window_s)
    else $error("call did not span four cycles");

  need_global_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RQ7
    call_start_o |-> $past(global_irq_enable_i, 2))
    else $error("call made with global enable low");

  vector_form_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RQ16
    call_start_o |-> (call_vector_o == 16'h0003 + {8'h00, $past(req_idx_reg), 3'h0}))
    else $error("vector not base plus eight per index");

  return_from_irq_op_gap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RQ9
    (instr_done_i && return_from_irq_op_done_i) |=> !call_start_o)
    else $error("call taken on the return instruction");

  hi_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RQ12
    (svc_hi_reg && !return_from_irq_op_done_i) |=> !call_start_o)
    else $error("high level routine preempted");

  lo_wait_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RQ15
    (call_start_o && $past(svc_lo_reg)) |-> $past(req_hi_reg))
    else $error("low routine preempted by equal level");

  auto_clr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RQ8
    (take && AUTO_CLR_MASK[req_idx_reg] && !hw_set[req_idx_reg]
     && !sw_flag_set_i[req_idx_reg]) |=> !flag_reg[$past(req_idx_reg)])
    else $error("auto-clear flag survived vectoring");

  fast_path_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RQ14
    (arb.valid && !svc_hi_reg && !svc_lo_reg && call_cnt_reg == 3'h0
     ##1 instr_done_i && !return_from_irq_op_done_i && call_cnt_reg == 3'h0) |=> call_start_o)
    else $error("sampled request not taken at instruction end");
endmodule
`default_nettype wire

// ---- bench/seq_model.sv ----
// instruction sequencer model: an instruction end at most every second cycle that the bench lets run
// assumes the handler's call_busy_o is fed back; changes only after a rising edge
`timescale 1ns/100ps
`default_nettype none
module seq_model (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic call_busy_i,
  input  wire logic stall_i,
  input  wire logic return_from_irq_op_i,
  output logic      instr_done_o,
  output logic      return_from_irq_op_done_o
);
  logic go;
  assign go = rst_n_i && !call_busy_i && !stall_i && !instr_done_o;
  initial begin
    instr_done_o = 1'b0;
    return_from_irq_op_done_o  = 1'b0;
  end
  // no instruction ends while the call sequence runs
  always @(posedge clk_sys_i) begin
    instr_done_o <= go;
    return_from_irq_op_done_o  <= go && return_from_irq_op_i;
  end
endmodule
`default_nettype wire

// ---- bench/cpu_interrupt_handler_test.sv ----
// self-checking bench for the interrupt handler
// assumes seq_model as sequencer; inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_handler_test;
  logic        clk_sys_i, rst_n_i, glb, idone, rdone, stall, rreq, cs, busy, hi, lo, got;
  logic [11:0] pev;
  logic [9:0]  pin_n, used;
  logic [21:0] sset, sclr, en, hp, pend;
  logic [15:0] vec;
  int          error_cnt, check_count, busy_n;
  cpu_interrupt_handler dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .periph_event_i(pev),
    .ext_pin_n_i(pin_n), .ext_pin_used_i(used), .sw_flag_set_i(sset), .sw_flag_clr_i(sclr),
    .global_irq_enable_i(glb), .src_enable_i(en), .src_high_prio_i(hp),
    .instr_done_i(idone), .return_from_irq_op_done_i(rdone), .pending_o(pend), .call_start_o(cs),
    .call_vector_o(vec), .call_busy_o(busy), .in_service_hi_o(hi), .in_service_lo_o(lo));
  seq_model seq (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .call_busy_i(busy),
    .stall_i(stall), .return_from_irq_op_i(rreq), .instr_done_o(idone), .return_from_irq_op_done_o(rdone));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string what, input logic [21:0] seen, input logic [21:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset;
    @(negedge clk_sys_i);
    rst_n_i = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
  endtask
  task automatic step(input logic r);
    @(negedge clk_sys_i);
    stall = 1'b0;
    rreq = r;
    @(negedge clk_sys_i);
    stall = 1'b1;
    rreq = 1'b0;
  endtask
  task automatic set_flags(input logic [21:0] m);
    @(negedge clk_sys_i);
    sset = m;
    @(negedge clk_sys_i);
    sset = 22'h000000;
  endtask
  task automatic wait_call(input int n);
    got = 1'b0;
    busy_n = 0;
    repeat (n) begin
      @(negedge clk_sys_i);
      if (cs === 1'b1) got = 1'b1;
      if (busy === 1'b1) busy_n++;
    end
  endtask
  initial begin
    {glb, stall, rreq, rst_n_i} = 4'h4;
    {pev, sset, sclr, hp} = '0;
    {pin_n, en} = '1;
    used = 10'h3ff;
    do_reset();
    chk("reset", pend, 22'h000000);
    chk("reset status", 22'({busy, hi, lo, cs}), 22'h000000);
    chk("reset vector", 22'(vec), 22'h000003);
    set_flags(22'h000004);
    glb = 1'b0;
    step(1'b0);
    wait_call(8);
    chk("global off", 22'(got), 22'h0);
    chk("flag set while off", pend, 22'h000004);
    glb = 1'b1;
    en = 22'h3ffffb;
    step(1'b0);
    wait_call(8);
    chk("source off", 22'(got), 22'h0);
    sclr = 22'h000004;
    @(negedge clk_sys_i);
    sclr = 22'h000000;
    en = 22'h3fffff;
    pev = 12'h008;
    @(negedge clk_sys_i);
    pev = 12'h000;
    step(1'b0);
    wait_call(8);
    chk("call", 22'({got, vec, lo}), 22'({1'b1, 16'h001b, 1'b1}));
    chk("call cycles", 22'(busy_n), 22'h4);
    chk("flag kept", pend, 22'h000008);
    hp = 22'h000600;
    set_flags(22'h000602);
    step(1'b0);
    wait_call(8);
    chk("preempt", 22'({got, vec, hi}), 22'({1'b1, 16'h004b, 1'b1}));
    step(1'b0);
    wait_call(8);
    chk("high kept", 22'(got), 22'h0);
    step(1'b1);
    wait_call(6);
    chk("after return", 22'(got), 22'h0);
    step(1'b0);
    wait_call(8);
    chk("re-entry", 22'({got, vec}), 22'({1'b1, 16'h004b}));
    do_reset();
    chk("flags cleared", pend, 22'h0);
    @(negedge clk_sys_i);
    pin_n = 10'h3ef;
    repeat (4) @(negedge clk_sys_i);
    chk("pin flag", pend, 22'h010000);
    step(1'b0);
    wait_call(8);
    chk("pin call", 22'({got, vec}), 22'({1'b1, 16'h0083}));
    chk("pin auto clear", pend, 22'h0);
    used = 10'h3df;
    pin_n = 10'h3cf;
    repeat (4) @(negedge clk_sys_i);
    chk("unused pin", pend, 22'h0);
    sset = 22'h000001;
    sclr = 22'h000001;
    @(negedge clk_sys_i);
    {sset, sclr} = '0;
    chk("set beats clear", pend, 22'h000001);
    results();
  end
  initial begin
    #20000;
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
